// ### src/mcc_pkg.sv
`default_nettype none
package mcc_pkg;
   // Register byte addresses on the bus
   localparam logic [11:0] MCC_ADDR_STATUS = 12'h000;
   localparam logic [11:0] MCC_ADDR_TRIM = 12'h004;
   // Field positions in the clock control/status register
   localparam int MCC_BIT_SLOW = 0;
   localparam int MCC_BIT_CLKOUT = 1;
   // Reset values
   localparam logic [7:0] MCC_STATUS_RST = 8'h00;
   localparam logic [7:0] MCC_TRIM_RST = 8'hff;
   localparam logic [1:0] MCC_LOWER_RST = 2'h3;
   // Slow mode divide ratio and its last counter value
   localparam int MCC_SLOW_DIV = 32;
   localparam logic [4:0] MCC_SLOW_LAST = 5'(MCC_SLOW_DIV - 1);
   // Bus answer phase
   typedef enum logic [1:0] {
      MCC_S_IDLE = 2'b01,
      MCC_S_RESP = 2'b10
   } mcc_apb_st_t;
endpackage
`default_nettype wire

// ### src/mcc_ctrl_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mcc_ctrl_if;
   logic clk_out_en;
   logic slow_mode;
   logic cpu_tick;
   logic clk_level;
   modport regs (output clk_out_en, output slow_mode,
                 input cpu_tick, input clk_level);
   modport div (input slow_mode, output cpu_tick, output clk_level);
   modport pin (input clk_out_en, input clk_level);
endinterface
`default_nettype wire

// ### src/mcc_clk_div.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_clk_div (
   input wire logic clock_in,
   input wire logic nrst_in,
   mcc_ctrl_if.div ctl
);
   logic [4:0] cnt_q;
   logic [4:0] cnt_d;
   logic tick_q;
   logic level_q;
   wire wrap = (cnt_q == mcc_pkg::MCC_SLOW_LAST);
   wire tick_d = ctl.slow_mode ? wrap : 1'b1;

   assign cnt_d = ctl.slow_mode ? cnt_q + 5'h01 : 5'h00;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         cnt_q <= 5'h00;
         tick_q <= 1'b0;
         level_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
         if (tick_d) begin
            level_q <= ~level_q;
         end
      end
   end

   assign ctl.cpu_tick = tick_q;
   assign ctl.clk_level = level_q;

   ////////////////////////////////////////////////////////////////////
   logic [5:0] gap_q;
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         gap_q <= 6'h00;
      end else if (tick_q || !ctl.slow_mode) begin
         gap_q <= 6'h00;
      end else begin
         gap_q <= gap_q + 6'h01;
      end
   end

   property p_slow_gap;
      @(posedge clock_in) disable iff (!nrst_in)
      (ctl.slow_mode && $past(ctl.slow_mode) && $rose(tick_q)
         && gap_q != 6'h00)
      |-> gap_q == 6'(mcc_pkg::MCC_SLOW_DIV - 1);
   endproperty
   a_slow_gap: assert property (p_slow_gap)
      else $error("slow mode tick spacing wrong");

   property p_level_on_tick;
      @(posedge clock_in) disable iff (!nrst_in)
      $changed(level_q) |-> $past(tick_d);
   endproperty
   a_level_on_tick: assert property (p_level_on_tick)
      else $error("clock output moved without a cpu tick");
endmodule
`default_nettype wire

// ### src/mcc_pin_mux.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_pin_mux (
   input wire logic clock_in,
   input wire logic nrst_in,
   mcc_ctrl_if.pin ctl,
   input wire logic port_data_in,
   input wire logic port_dir_in,
   input wire logic port_pull_in,
   input wire logic pin_in,
   output logic pin_out,
   output logic pin_oe_out,
   output logic pull_up_out,
   output logic pin_state_out
);
   wire drv_d = ctl.clk_out_en ? ctl.clk_level : port_data_in;
   wire oe_d = ctl.clk_out_en | port_dir_in;
   wire pull_d = ~oe_d & port_pull_in;

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         pin_out <= 1'b0;
         pin_oe_out <= 1'b0;
         pull_up_out <= 1'b1;
         pin_state_out <= 1'b0;
      end else begin
         pin_out <= drv_d;
         pin_oe_out <= oe_d;
         pull_up_out <= pull_d;
         pin_state_out <= pin_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   property p_reset_pin;
      @(posedge clock_in) disable iff (!nrst_in)
      !$past(nrst_in) |-> pull_up_out && !pin_oe_out;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("pin not input with pull-up after reset");

   property p_override;
      @(posedge clock_in) disable iff (!nrst_in)
      ctl.clk_out_en |=> pin_oe_out && pin_out == $past(ctl.clk_level)
         && pin_state_out == $past(pin_in);
   endproperty
   a_override: assert property (p_override)
      else $error("clock output does not own the pin");
endmodule
`default_nettype wire

// ### src/mcc_top.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Bit 1 enables clock output on shared pin; cleared by reset.
// - Bit 0 selects slow mode, cpu clock is oscillator over 32.
// - Trim register is eight read/write bits, reset to all ones.
// - Lower trim code gives higher frequency; zero fastest, ones slowest.
// - Eight upper trim bits join two outside lower bits, ten total.
// - Any reset returns shared pin to input with pull-up.
// - Enabled clock output drives pin; port read still shows pin.
module mcc_top #(
   parameter int ADDR_W = 12
) (
   input wire logic clock_in,
   input wire logic nrst_in,
   input wire logic psel_in,
   input wire logic penable_in,
   input wire logic pwrite_in,
   input wire logic [ADDR_W-1:0] paddr_in,
   input wire logic [31:0] pwdata_in,
   input wire logic [3:0] pstrb_in,
   output logic [31:0] prdata_out,
   output logic pready_out,
   output logic pslverr_out,
   input wire logic [1:0] trim_lower_bits_in,
   output logic [9:0] trim_value_out,
   output logic cpu_clk_en_out,
   input wire logic port_data_in,
   input wire logic port_dir_in,
   input wire logic port_pull_in,
   input wire logic clk_pin_in,
   output logic clk_pin_out,
   output logic clk_pin_oe_out,
   output logic clk_pin_pull_up_out,
   output logic clk_pin_state_out
);
   ////////////////////////////////////////////////////////////////////
   function automatic logic addr_is(input logic [ADDR_W-1:0] a,
                                    input logic [11:0] r);
      addr_is = (a == ADDR_W'(r));
   endfunction

   mcc_ctrl_if ctl ();

   mcc_pkg::mcc_apb_st_t st_q;
   mcc_pkg::mcc_apb_st_t st_d;
   logic clk_out_enable_q;
   logic slow_mode_select_q;
   logic [7:0] trim_upper_bits_q;
   logic [9:0] trim_value_q;
   logic [31:0] rdata_q;
   logic ready_q;
   logic err_q;

   ////////////////////////////////////////////////////////////////////
   wire hit_status = addr_is(paddr_in, mcc_pkg::MCC_ADDR_STATUS);
   wire hit_trim = addr_is(paddr_in, mcc_pkg::MCC_ADDR_TRIM);
   wire hit = hit_status | hit_trim;
   wire access = psel_in & penable_in;
   wire in_resp = (st_q == mcc_pkg::MCC_S_RESP);
   // Write lands only on the edge that samples pready high
   wire commit = in_resp & access & pwrite_in & hit & pstrb_in[0];
   wire wr_status = commit & hit_status;
   wire wr_trim = commit & hit_trim;

   wire [7:0] status_rd = {6'h00, clk_out_enable_q, slow_mode_select_q};
   wire [7:0] sel_rd = hit_status ? status_rd :
                       hit_trim ? trim_upper_bits_q : 8'h00;
   wire [31:0] rdata_d = pwrite_in ? 32'h0000_0000 : {24'h00_0000, sel_rd};

   always_comb begin
      st_d = st_q;
      case (st_q)
         mcc_pkg::MCC_S_IDLE: begin
            if (access) begin
               st_d = mcc_pkg::MCC_S_RESP;
            end
         end
         mcc_pkg::MCC_S_RESP: begin
            st_d = mcc_pkg::MCC_S_IDLE;
         end
         default: begin
            st_d = mcc_pkg::MCC_S_IDLE;
         end
      endcase
   end

   // One wait state keeps every bus output on a flip-flop
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         st_q <= mcc_pkg::MCC_S_IDLE;
         ready_q <= 1'b0;
         err_q <= 1'b0;
         rdata_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
         ready_q <= (st_d == mcc_pkg::MCC_S_RESP);
         err_q <= (st_d == mcc_pkg::MCC_S_RESP) & ~hit;
         rdata_q <= (st_d == mcc_pkg::MCC_S_RESP) ? rdata_d : 32'h0000_0000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // clock output enable bit
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         clk_out_enable_q <= mcc_pkg::MCC_STATUS_RST[mcc_pkg::MCC_BIT_CLKOUT];
      end else if (wr_status) begin
         clk_out_enable_q <= pwdata_in[mcc_pkg::MCC_BIT_CLKOUT];
      end
   end

   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         slow_mode_select_q <= mcc_pkg::MCC_STATUS_RST[mcc_pkg::MCC_BIT_SLOW];
      end else if (wr_status) begin
         slow_mode_select_q <= pwdata_in[mcc_pkg::MCC_BIT_SLOW];
      end
   end

   // trim register, all ones at reset
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trim_upper_bits_q <= mcc_pkg::MCC_TRIM_RST;
      end else if (wr_trim) begin
         trim_upper_bits_q <= pwdata_in[7:0];
      end
   end

   // ten-bit code, passed uninverted so ones mean slowest
   always_ff @(posedge clock_in or negedge nrst_in) begin
      if (!nrst_in) begin
         trim_value_q <= {mcc_pkg::MCC_TRIM_RST, mcc_pkg::MCC_LOWER_RST};
      end else begin
         trim_value_q <= {trim_upper_bits_q, trim_lower_bits_in};
      end
   end

   ////////////////////////////////////////////////////////////////////
   assign ctl.clk_out_en = clk_out_enable_q;
   assign ctl.slow_mode = slow_mode_select_q;

   mcc_clk_div u_div (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ctl(ctl.div)
   );

   mcc_pin_mux u_pin (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .ctl(ctl.pin),
      .port_data_in(port_data_in),
      .port_dir_in(port_dir_in),
      .port_pull_in(port_pull_in),
      .pin_in(clk_pin_in),
      .pin_out(clk_pin_out),
      .pin_oe_out(clk_pin_oe_out),
      .pull_up_out(clk_pin_pull_up_out),
      .pin_state_out(clk_pin_state_out)
   );

   assign prdata_out = rdata_q;
   assign pready_out = ready_q;
   assign pslverr_out = err_q;
   assign trim_value_out = trim_value_q;
   assign cpu_clk_en_out = ctl.cpu_tick;

   ////////////////////////////////////////////////////////////////////
   property p_clkout_write;
      @(posedge clock_in) disable iff (!nrst_in)
      wr_status |=> clk_out_enable_q == $past(pwdata_in[1])
         ##1 (!$past(clk_out_enable_q) || clk_pin_oe_out);
   endproperty
   a_clkout_write: assert property (p_clkout_write)
      else $error("clock output enable did not take the write");

   property p_slow_read;
      @(posedge clock_in) disable iff (!nrst_in)
      (access && !pwrite_in && hit_status && !in_resp)
      |=> pready_out && prdata_out[7:0] == {6'h00,
         clk_out_enable_q, slow_mode_select_q};
   endproperty
   a_slow_read: assert property (p_slow_read)
      else $error("status read back wrong or late");

   property p_trim_reset;
      @(posedge clock_in) disable iff (!nrst_in)
      !$past(nrst_in) |-> trim_upper_bits_q == mcc_pkg::MCC_TRIM_RST
         && !clk_out_enable_q && !slow_mode_select_q;
   endproperty
   a_trim_reset: assert property (p_trim_reset)
      else $error("register reset values wrong");

   property p_trim_write;
      @(posedge clock_in) disable iff (!nrst_in)
      wr_trim |=> trim_upper_bits_q == $past(pwdata_in[7:0])
         ##1 trim_value_out[9:2] == $past(trim_upper_bits_q);
   endproperty
   a_trim_write: assert property (p_trim_write)
      else $error("trim code not passed on as written");

   property p_trim_join;
      @(posedge clock_in) disable iff (!nrst_in)
      1'b1 |=> trim_value_out == {$past(trim_upper_bits_q),
         $past(trim_lower_bits_in)};
   endproperty
   a_trim_join: assert property (p_trim_join)
      else $error("ten-bit trim code badly joined");

   property p_one_wait;
      @(posedge clock_in) disable iff (!nrst_in)
      pready_out |=> !pready_out && !pslverr_out;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("pready held longer than one cycle");

   ////////////////////////////////////////////////////////////////////
   // Refused access answers with an error and zero data
   property p_unmapped;
      @(posedge clock_in) disable iff (!nrst_in)
      (access && !in_resp && !hit)
      |=> pready_out && pslverr_out && prdata_out == 32'h0000_0000;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped access not refused");

   // A refused or masked write leaves every register alone
   property p_no_commit;
      @(posedge clock_in) disable iff (!nrst_in)
      (in_resp && access && pwrite_in && !(hit && pstrb_in[0]))
      |=> $stable(trim_upper_bits_q) && $stable(clk_out_enable_q)
         && $stable(slow_mode_select_q);
   endproperty
   a_no_commit: assert property (p_no_commit)
      else $error("ignored write changed a register");

   property p_reserved_zero;
      @(posedge clock_in) disable iff (!nrst_in)
      (pready_out && hit_status) |-> prdata_out[31:2] == 30'h0000_0000;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero)
      else $error("reserved status bits read nonzero");

   property p_slow_write;
      @(posedge clock_in) disable iff (!nrst_in)
      wr_status |=> slow_mode_select_q == $past(pwdata_in[0]);
   endproperty
   a_slow_write: assert property (p_slow_write)
      else $error("slow mode select did not take the write");

   property p_normal_tick;
      @(posedge clock_in) disable iff (!nrst_in)
      !slow_mode_select_q |=> cpu_clk_en_out;
   endproperty
   a_normal_tick: assert property (p_normal_tick)
      else $error("cpu clock enable dropped in normal mode");

   property p_slow_pulse;
      @(posedge clock_in) disable iff (!nrst_in)
      (slow_mode_select_q && cpu_clk_en_out) |=> !cpu_clk_en_out;
   endproperty
   a_slow_pulse: assert property (p_slow_pulse)
      else $error("slow mode tick longer than one cycle");

   property p_trim_extremes;
      @(posedge clock_in) disable iff (!nrst_in)
      (trim_upper_bits_q == 8'h00 || trim_upper_bits_q == 8'hff)
      |=> trim_value_out[9:2] == $past(trim_upper_bits_q);
   endproperty
   a_trim_extremes: assert property (p_trim_extremes)
      else $error("trim end code not passed on unchanged");

   // Bus outputs stay quiet between answers
   property p_bus_idle;
      @(posedge clock_in) disable iff (!nrst_in)
      !pready_out |-> prdata_out == 32'h0000_0000 && !pslverr_out;
   endproperty
   a_bus_idle: assert property (p_bus_idle)
      else $error("bus outputs not quiet outside an answer");

   property p_reset_outputs;
      @(posedge clock_in) disable iff (!nrst_in)
      !$past(nrst_in) |-> !pready_out && !cpu_clk_en_out
         && trim_value_out == {mcc_pkg::MCC_TRIM_RST,
         mcc_pkg::MCC_LOWER_RST};
   endproperty
   a_reset_outputs: assert property (p_reset_outputs)
      else $error("outputs not at reset values after reset");
endmodule
`default_nettype wire

// ### dv/mcc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module mcc_top_test;
   logic clock_in, nrst_in, psel, pen, pwr, ext_q, pull, pready, perr;
   logic cpu_en, pin_o, pin_oe, pin_pu, pin_st, pin_w, err, pdat, pdir;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] pstrb;
   logic [1:0] low;
   logic [9:0] trim_v;
   int bad_count, n_tests, en_c, tg_c;
   // Pin level as the outside world sees it: our drive wins while enabled
   assign pin_w = pin_oe ? pin_o : ext_q;
   mcc_top DUT (.clock_in(clock_in), .nrst_in(nrst_in), .psel_in(psel),
      .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
      .pwdata_in(pwdata), .pstrb_in(pstrb), .prdata_out(prdata),
      .pready_out(pready), .pslverr_out(perr), .trim_lower_bits_in(low),
      .trim_value_out(trim_v), .cpu_clk_en_out(cpu_en),
      .port_data_in(pdat), .port_dir_in(pdir), .port_pull_in(pull),
      .clk_pin_in(pin_w), .clk_pin_out(pin_o), .clk_pin_oe_out(pin_oe),
      .clk_pin_pull_up_out(pin_pu), .clk_pin_state_out(pin_st));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Starts one edge late so psel never gets two assignments in a step
   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, input logic [3:0] s);
      @(posedge clock_in);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clock_in);
      pen <= 1'b1;
      do @(posedge clock_in); while (pready !== 1'b1);
      rd = prdata;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, 4'h1);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0, 4'h1);
      chk(rd, exp);
      chk(32'(err), 32'h0);
   endtask
   task automatic count(input int n);
      logic prev;
      en_c = 0;
      tg_c = 0;
      repeat (4) @(posedge clock_in);
      prev = pin_o;
      repeat (n) begin
         @(posedge clock_in);
         if (cpu_en === 1'b1) en_c++;
         if (pin_o !== prev) tg_c++;
         prev = pin_o;
      end
   endtask
   task automatic complete_run;
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_reset;
      chk(32'(trim_v), 32'h3ff);
      chk(32'({pin_oe, pin_pu, cpu_en}), 32'h2);
      @(posedge clock_in);
      nrst_in <= 1'b1;
      rdc(mcc_pkg::MCC_ADDR_STATUS, 32'h0);
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'hff);
   endtask
   task automatic t_trim;
      low <= 2'h1;
      wr(mcc_pkg::MCC_ADDR_TRIM, 32'h80);
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'h80);
      repeat (2) @(posedge clock_in);
      chk(32'(trim_v), 32'h201);
      apb(1'b1, mcc_pkg::MCC_ADDR_TRIM, 32'h0, 4'h0);
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'h80);
      apb(1'b0, 12'h008, 32'h0, 4'h1);
      chk({rd[30:0], err}, 32'h1);
      wr(mcc_pkg::MCC_ADDR_TRIM, 32'h00);
      low <= 2'h2;
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'h00);
      chk(32'(trim_v), 32'h002);
   endtask
   task automatic t_slow;
      wr(mcc_pkg::MCC_ADDR_STATUS, 32'h1);
      rdc(mcc_pkg::MCC_ADDR_STATUS, 32'h1);
      count(64);
      chk(32'(en_c), 32'h2);
      wr(mcc_pkg::MCC_ADDR_STATUS, 32'h0);
      count(64);
      chk(32'(en_c), 32'h40);
   endtask
   task automatic t_pin;
      chk(32'(pin_pu), 32'h0);
      ext_q <= 1'b1;
      pull <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk(32'({pin_st, pin_pu, pin_oe}), 32'h6);
      // Ordinary port output first, then data left high under the clock
      pdir <= 1'b1;
      pdat <= 1'b1;
      repeat (3) @(posedge clock_in);
      chk(32'({pin_o, pin_oe, pin_pu}), 32'h6);
      pdir <= 1'b0;
      wr(mcc_pkg::MCC_ADDR_STATUS, 32'h2);
      rdc(mcc_pkg::MCC_ADDR_STATUS, 32'h2);
      count(64);
      chk(32'({pin_oe, pin_pu}), 32'h2);
      chk(32'(pin_st ^ pin_o), 32'h1);
      chk(32'(tg_c), 32'h40);
      wr(mcc_pkg::MCC_ADDR_STATUS, 32'hff);
      rdc(mcc_pkg::MCC_ADDR_STATUS, 32'h3);
      count(64);
      chk(32'(tg_c), 32'h2);
   endtask
   task automatic t_rst;
      nrst_in <= 1'b0;
      repeat (2) @(posedge clock_in);
      chk(32'({pin_oe, pin_pu}), 32'h1);
      nrst_in <= 1'b1;
      rdc(mcc_pkg::MCC_ADDR_STATUS, 32'h0);
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'hff);
      chk(32'(pin_oe), 32'h0);
      wr(mcc_pkg::MCC_ADDR_TRIM, 32'h5a);
      rdc(mcc_pkg::MCC_ADDR_TRIM, 32'h5a);
      chk(32'(trim_v), 32'h16a);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   initial begin
      repeat (5000) @(posedge clock_in);
      bad_count++;
      complete_run;
   end
   initial begin
      nrst_in = 1'b0;
      {psel, pen, pwr, ext_q, pull, pdat, pdir} = 7'h00;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'h0;
      low = 2'h3;
      bad_count = 0;
      n_tests = 0;
      repeat (12) @(posedge clock_in);
      t_reset;
      t_trim;
      t_slow;
      t_pin;
      t_rst;
      complete_run;
   end
endmodule
`default_nettype wire
